// ===== core/smon_defs.svh
`ifndef SMON_DEFS_SVH
`define SMON_DEFS_SVH

// Core clock rate and the one-microsecond tick derived from it
`define SMON_CLK_MHZ 250
`define SMON_US_CYC (`SMON_CLK_MHZ)

// Interrupt pin timing, in microseconds
`define SMON_INT_LOW_US 16'h07d0
`define SMON_INT_HIGH_US 16'h0fa0

// Gap between last input sample and clean-current start, in microseconds
`define SMON_CCP_GAP_US 16'h0014

// Fault to interrupt pin reaction limit, in microseconds
`define SMON_REACT_US 20

// Reinitialisation limit with an interrupt pending, in microseconds
`define SMON_RST_PEND_US 1000

// Trim load and self-check duration, in clock cycles
`define SMON_INIT_CYC 64

// Widths of configuration words and timers
`define SMON_CFG_W 16
`define SMON_CNT_W 16

// Reset values
`define SMON_CFG_RST 16'h0000
`define SMON_CCP_RST 16'h0010
`define SMON_SYNC_INIT 7'h20

// Positions in the synchroniser vector
`define SMON_SY_RST 6
`define SMON_SY_CS 5
`define SMON_SY_VDD 4

`endif

// ===== core/smon_pkg.sv
package smon_pkg;
    `include "smon_defs.svh"

    // Control sequencer states
    typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_IDLE, ST_RUN} ctrl_state_t;

    // Phases of one polling period
    typedef enum logic [1:0] {PH_ACT, PH_GAP, PH_CCP, PH_WAIT} poll_phase_t;

    // Analog fault levels
    typedef struct packed {
        logic supply_high_fault;
        logic supply_low_fault;
        logic thermal_warning;
        logic thermal_shutdown;
    } fault_t;

    // Interrupt status register
    typedef struct packed {
        logic por;
        logic selftest_fail_flag;
        fault_t fault;
    } int_stat_t;

    // A write strobe with its data word
    typedef struct packed {
        logic valid;
        logic [`SMON_CFG_W-1:0] data;
    } cfg_wr_t;
endpackage

// ===== core/int_pin_seq.sv
`timescale 1ns/100ps
`include "smon_defs.svh"

// Interrupt pin pulse train: low phase, release phase, repeat while pending
module int_pin_seq #(
    parameter int CNT_W = `SMON_CNT_W,
    parameter logic [`SMON_CNT_W-1:0] LOW_US = `SMON_INT_LOW_US,
    parameter logic [`SMON_CNT_W-1:0] HIGH_US = `SMON_INT_HIGH_US
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic new_event,
    input wire logic pending,
    output logic int_n
);
    typedef enum logic [1:0] {IP_IDLE, IP_LOW, IP_HIGH} ip_state_t;

    ip_state_t st_q;                  // Pin phase
    ip_state_t st_d;
    logic [CNT_W-1:0] cnt_q;          // Microseconds spent in phase
    wire low_end = tick && (cnt_q >= LOW_US - 1'b1);
    wire high_end = tick && (cnt_q >= HIGH_US - 1'b1);
    wire restart = (st_d != st_q) || new_event;

    // Next phase; a fresh event always pulls the pin low at once
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            IP_IDLE: if (new_event) st_d = IP_LOW;
            IP_LOW: if (low_end) st_d = pending ? IP_HIGH : IP_IDLE;
            IP_HIGH: if (high_end) st_d = IP_LOW;
            default: st_d = IP_IDLE;
        endcase
        if (!pending && !new_event)
            st_d = IP_IDLE;
        else if (new_event)
            st_d = IP_LOW;
    end

    // Phase register and its microsecond counter
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= IP_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= restart ? '0 : cnt_q + CNT_W'(tick);
        end
    end

    // Registered pin, low only in the low phase
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            int_n <= 1'b1;
        else
            int_n <= (st_d != IP_LOW);
    end

    low_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st_q == IP_LOW && low_end && pending && !new_event |=> st_q == IP_HIGH)
        else $error("low phase did not end after its length");
endmodule

// ===== core/switch_monitor_init_reset_ctrl.sv
`timescale 1ns/100ps
`include "smon_defs.svh"

// Functional notes
// - Poll window and period held to programmed length
// - Clean-current phase held to programmed length
// - Wait 20 us after last sample
// - Interrupt low pulse lasts 2 ms
// - Interrupt released 4 ms between pulses
// - Fault pulls interrupt low within 20 us
// - Reset with pending interrupt ends within 1 ms
// - Logic supply loss stops SPI, keeps registers
// - Init end: defaults, interrupt, power-on flags
// - Self-check failure flagged with power-on flag
// - Run bit set starts monitoring
// - Running locks config except listed bits
// - Clearing run bit stops monitoring for reconfiguration
// - CRC check usable while running
// - Reset pin high holds reset, clears registers
// - Reset pin low reinitialises with power-on flags
// - Soft reset bit restores all defaults
// - Soft reset end raises interrupt and flags
// - Chip select rise after status read clears interrupt
module switch_monitor_init_reset_ctrl #(
    parameter int TICK_CYC = `SMON_US_CYC,
    parameter logic [`SMON_CNT_W-1:0] INT_LOW_US = `SMON_INT_LOW_US,
    parameter logic [`SMON_CNT_W-1:0] INT_HIGH_US = `SMON_INT_HIGH_US,
    parameter int INIT_CYC = `SMON_INIT_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reset_pin,
    input wire logic cs_n,
    input wire logic vdd_ok,
    input wire smon_pkg::fault_t fault_pin,
    input wire logic selftest_pass,
    input wire smon_pkg::cfg_wr_t cfg_wr,
    input wire smon_pkg::cfg_wr_t ccp_wr,
    input wire logic run_wr,
    input wire logic run_wdata,
    input wire logic swrst_wr,
    input wire logic crc_req,
    input wire logic int_stat_rd,
    input wire logic [`SMON_CNT_W-1:0] poll_act_us,
    input wire logic [`SMON_CNT_W-1:0] poll_per_us,
    output logic int_n,
    output smon_pkg::int_stat_t int_stat,
    output logic spi_por_flag,
    output logic spi_en,
    output logic run_on,
    output logic monitor_en,
    output logic wet_en,
    output logic sample_last,
    output logic ccp_en,
    output logic crc_en,
    output logic cfg_wr_ok,
    output logic [`SMON_CFG_W-1:0] cfg_word,
    output logic [`SMON_CFG_W-1:0] clean_current_cfg_reg,
    output smon_pkg::ctrl_state_t ctrl_state
);
    localparam int CW = `SMON_CNT_W;
    localparam logic [CW-1:0] GAP_US = `SMON_CCP_GAP_US;

    // Two-stage synchronisers for every asynchronous input
    wire [6:0] sy_in = {reset_pin, cs_n, vdd_ok, fault_pin};
    logic [6:0] sy1_q;                 // First stage, read only by the second
    logic [6:0] sy2_q;                 // Second stage, safe to use
    localparam logic [6:0] SY_INIT = `SMON_SYNC_INIT;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sy1_q[gi] <= SY_INIT[gi];
                    sy2_q[gi] <= SY_INIT[gi];
                end
                else
                begin
                    sy1_q[gi] <= sy_in[gi];
                    sy2_q[gi] <= sy1_q[gi];
                end
            end
        end
    endgenerate

    wire rst_s = sy2_q[`SMON_SY_RST];
    wire cs_s = sy2_q[`SMON_SY_CS];
    wire vdd_s = sy2_q[`SMON_SY_VDD];
    smon_pkg::fault_t flt_s;
    assign flt_s = sy2_q[3:0];

    // Delayed copies for edge detection
    logic cs_d_q;                      // Chip select one cycle ago
    smon_pkg::fault_t flt_d_q;         // Fault levels one cycle ago
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_d_q <= 1'b1;
            flt_d_q <= '0;
        end
        else
        begin
            cs_d_q <= cs_s;
            flt_d_q <= flt_s;
        end
    end
    wire cs_rise = cs_s && !cs_d_q;
    // Both edges of a fault raise an event: entering and leaving a condition
    wire [3:0] flt_evt = flt_s ^ flt_d_q;

    // Free-running microsecond tick; all long timing counts these
    logic [CW-1:0] div_q;
    wire tick = (div_q == CW'(TICK_CYC - 1));
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            div_q <= '0;
        else
            div_q <= tick ? '0 : div_q + 1'b1;
    end

    // Sequencer state
    smon_pkg::ctrl_state_t st_q;
    smon_pkg::ctrl_state_t st_d;
    logic [CW-1:0] init_cnt_q;         // Cycles spent loading trim
    logic run_q;                       // Run bit

    wire in_init = (st_q == smon_pkg::ST_INIT);
    wire init_done = in_init && (init_cnt_q == CW'(INIT_CYC - 1));
    // SPI only works with a valid logic supply and a settled core
    wire spi_ok = vdd_s && (st_q == smon_pkg::ST_IDLE || st_q == smon_pkg::ST_RUN);
    wire swrst_go = swrst_wr && spi_ok;
    // Everything returns to defaults here; the pin holds it while high
    wire reg_clr = (st_q == smon_pkg::ST_RESET) || swrst_go;

    // Sequencer transitions
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            smon_pkg::ST_RESET: st_d = smon_pkg::ST_INIT;
            smon_pkg::ST_INIT: if (init_done) st_d = smon_pkg::ST_IDLE;
            smon_pkg::ST_IDLE: if (run_q) st_d = smon_pkg::ST_RUN;
            smon_pkg::ST_RUN: if (!run_q) st_d = smon_pkg::ST_IDLE;
            default: st_d = smon_pkg::ST_RESET;
        endcase
        // Soft reset restarts init without waiting on the interrupt pin
        if (swrst_go)
            st_d = smon_pkg::ST_INIT;
        if (rst_s)
            st_d = smon_pkg::ST_RESET;
    end

    // Sequencer register and init counter
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= smon_pkg::ST_INIT;
            init_cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            init_cnt_q <= (in_init && st_d == smon_pkg::ST_INIT) ? init_cnt_q + 1'b1 : '0;
        end
    end

    // Configuration words; logic supply loss does not touch them
    logic [`SMON_CFG_W-1:0] cfg_q;
    logic [`SMON_CFG_W-1:0] ccp_q;
    assign cfg_wr_ok = cfg_wr.valid && spi_ok && !run_q && !swrst_go;
    wire ccp_wr_ok = ccp_wr.valid && spi_ok && !swrst_go;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_q <= `SMON_CFG_RST;
            ccp_q <= `SMON_CCP_RST;
            run_q <= 1'b0;
        end
        else if (reg_clr)
        begin
            cfg_q <= `SMON_CFG_RST;
            ccp_q <= `SMON_CCP_RST;
            run_q <= 1'b0;
        end
        else
        begin
            // Locked while running; clean-current settings stay open
            if (cfg_wr_ok)
                cfg_q <= cfg_wr.data;
            if (ccp_wr_ok)
                ccp_q <= ccp_wr.data;
            if (run_wr && spi_ok)
                run_q <= run_wdata;
        end
    end

    // Interrupt status: events set, a read-then-release clears, set wins
    smon_pkg::int_stat_t stat_q;
    smon_pkg::int_stat_t stat_set;
    logic rd_seen_q;                   // Status read in this frame
    assign stat_set = {init_done, init_done && !selftest_pass,
                       flt_evt & {4{!in_init && st_q != smon_pkg::ST_RESET}}};
    wire stat_clr = reg_clr || (cs_rise && rd_seen_q);
    wire any_set = |stat_set;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stat_q <= '0;
            rd_seen_q <= 1'b0;
        end
        else
        begin
            stat_q <= (stat_clr ? '0 : stat_q) | stat_set;
            // Only reads taken inside a frame arm the clear
            if (cs_rise || reg_clr)
                rd_seen_q <= 1'b0;
            else if (int_stat_rd && !cs_s && spi_ok)
                rd_seen_q <= 1'b1;
        end
    end

    // Interrupt pin pulse train
    wire int_pend = |stat_q;
    int_pin_seq #(
        .CNT_W(CW),
        .LOW_US(INT_LOW_US),
        .HIGH_US(INT_HIGH_US)
    ) u_int (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(tick),
        .new_event(any_set),
        .pending(int_pend),
        .int_n(int_n)
    );

    // Polling engine; supply faults stop monitoring while their synchronised fault level is present
    smon_pkg::poll_phase_t ph_q;
    smon_pkg::poll_phase_t ph_d;
    logic [CW-1:0] ph_cnt_q;           // Microseconds in this phase
    logic [CW-1:0] per_cnt_q;          // Microseconds in this period
    logic [CW-1:0] ph_len;
    wire mon = (st_q == smon_pkg::ST_RUN) && run_q
               && !flt_s.supply_high_fault && !flt_s.supply_low_fault;

    // Length of the current phase
    always_comb
    begin
        case (ph_q)
            smon_pkg::PH_ACT: ph_len = poll_act_us;
            smon_pkg::PH_GAP: ph_len = GAP_US;
            smon_pkg::PH_CCP: ph_len = ccp_q;
            default: ph_len = '1;
        endcase
    end

    // Exact counts on the tick: length error is far inside twelve percent
    wire ph_end = tick && (ph_cnt_q >= ph_len - 1'b1) && (ph_q != smon_pkg::PH_WAIT);
    wire per_end = tick && (per_cnt_q >= poll_per_us - 1'b1);

    // Phase order; a short period cuts a late phase rather than stretch
    always_comb
    begin
        ph_d = ph_q;
        if (per_end)
            ph_d = smon_pkg::PH_ACT;
        else if (ph_end)
        begin
            case (ph_q)
                smon_pkg::PH_ACT: ph_d = smon_pkg::PH_GAP;
                smon_pkg::PH_GAP: ph_d = smon_pkg::PH_CCP;
                smon_pkg::PH_CCP: ph_d = smon_pkg::PH_WAIT;
                default: ph_d = smon_pkg::PH_WAIT;
            endcase
        end
    end

    // Phase registers, parked at the window start while stopped
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ph_q <= smon_pkg::PH_ACT;
            ph_cnt_q <= '0;
            per_cnt_q <= '0;
        end
        else if (!mon)
        begin
            ph_q <= smon_pkg::PH_ACT;
            ph_cnt_q <= '0;
            per_cnt_q <= '0;
        end
        else
        begin
            ph_q <= ph_d;
            ph_cnt_q <= (ph_d != ph_q) ? '0 : ph_cnt_q + CW'(tick);
            per_cnt_q <= per_end ? '0 : per_cnt_q + CW'(tick);
        end
    end

    // Registered sample strobe at the end of the active window
    logic sample_q;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            sample_q <= 1'b0;
        else
            sample_q <= mon && ph_end && (ph_q == smon_pkg::PH_ACT);
    end

    // Outputs
    assign int_stat = stat_q;
    assign spi_por_flag = stat_q.por;
    assign spi_en = spi_ok;
    assign run_on = run_q;
    assign monitor_en = mon;
    assign wet_en = mon && (ph_q == smon_pkg::PH_ACT || ph_q == smon_pkg::PH_CCP);
    assign ccp_en = mon && (ph_q == smon_pkg::PH_CCP);
    assign sample_last = sample_q;
    assign crc_en = crc_req && spi_ok;
    assign cfg_word = cfg_q;
    assign clean_current_cfg_reg = ccp_q;
    assign ctrl_state = st_q;

    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    reset_hold_a: assert property (rst_s |=> st_q == smon_pkg::ST_RESET && !spi_en)
        else $error("reset pin did not hold reset");
    pin_reinit_a: assert property ($fell(rst_s) |-> ##[1:2] st_q == smon_pkg::ST_INIT)
        else $error("no reinit after reset pin release");
    init_por_a: assert property (init_done && !rst_s |=> stat_q.por ##1 !int_n)
        else $error("init end without power-on flag");
    selftest_flag_a: assert property (init_done && !selftest_pass && !rst_s
        |=> stat_q.selftest_fail_flag && stat_q.por)
        else $error("self-check fail not flagged");
    cfg_lock_a: assert property (run_q && !reg_clr |=> $stable(cfg_q))
        else $error("config changed while running");
    ccp_open_a: assert property (ccp_wr_ok && !rst_s |=> ccp_q == $past(ccp_wr.data))
        else $error("clean-current write lost");
    run_gate_a: assert property (wet_en |-> run_q && st_q == smon_pkg::ST_RUN)
        else $error("wetting without run bit");
    crc_avail_a: assert property (crc_req && st_q == smon_pkg::ST_RUN && vdd_s |-> crc_en)
        else $error("crc blocked while running");
    swrst_a: assert property (swrst_go && !rst_s |=> st_q == smon_pkg::ST_INIT
        && cfg_q == `SMON_CFG_RST && !run_q)
        else $error("soft reset did not restore defaults");
    vdd_keep_a: assert property (!vdd_s && !reg_clr |-> !spi_en ##1 $stable(cfg_q))
        else $error("supply loss changed config or kept spi");
    read_clear_a: assert property (cs_rise && rd_seen_q && !any_set && !rst_s
        |=> stat_q == '0 ##2 int_n)
        else $error("status not cleared after read");
    fault_react_a: assert property (any_set |-> ##[1:2] !int_n)
        else $error("fault did not pull interrupt low");
    gap_len_a: assert property (ph_q == smon_pkg::PH_GAP && ph_end && mon && !per_end
        |-> ph_cnt_q == GAP_US - 1'b1)
        else $error("gap length wrong");

    cov_run: cover property (st_q == smon_pkg::ST_IDLE ##1 st_q == smon_pkg::ST_RUN);
    cov_ccp: cover property (ccp_en);
    cov_clear: cover property (cs_rise && rd_seen_q);
    cov_swrst: cover property (swrst_go);
endmodule

// ===== tb/host_model.sv
`timescale 1ns/100ps

// Host controller model: frames chip select, reads status, pulses reset
module host_model (
    input wire logic clk_sys,
    output logic cs_n,
    output logic int_stat_rd,
    output logic reset_pin
);
    // Idle: chip select high, reset pin at its pulled-down level
    initial
    begin
        cs_n = 1'h1;
        int_stat_rd = 1'h0;
        reset_pin = 1'h0;
    end

    // One frame of 8 link clocks of 80 ns, with an optional status read
    task automatic frame(input logic rd);
        @(negedge clk_sys);
        cs_n = 1'h0;
        #320;
        @(negedge clk_sys);
        int_stat_rd = rd;
        @(negedge clk_sys);
        int_stat_rd = 1'h0;
        #320;
        @(negedge clk_sys);
        cs_n = 1'h1;
        // Gap before any later frame may start
        #1500;
    endtask

    // Hold the reset pin high for n clocks, then return it low
    task automatic hw_reset(input int n);
        @(negedge clk_sys);
        reset_pin = 1'h1;
        repeat (n) @(negedge clk_sys);
        reset_pin = 1'h0;
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`include "smon_defs.svh"

// Bench for the control core; one microsecond is shortened to 4 clocks
module tb_top;
    logic clk_sys, sys_rst, vdd_ok, selftest_pass, run_wr, run_wdata, swrst_wr, crc_req;
    logic reset_pin, cs_n, int_stat_rd, int_n, spi_por_flag, spi_en, run_on, monitor_en;
    logic wet_en, sample_last, ccp_en, crc_en, cfg_wr_ok;
    logic [15:0] poll_act_us, poll_per_us, cfg_word, clean_current_cfg_reg;
    smon_pkg::fault_t fault_pin;
    smon_pkg::cfg_wr_t cfg_wr, ccp_wr;
    smon_pkg::int_stat_t int_stat;
    smon_pkg::ctrl_state_t ctrl_state;
    int err_count = 0;
    int n_checks = 0;

    // Short counts keep the pulse trains to tens of clocks
    switch_monitor_init_reset_ctrl #(.TICK_CYC(4), .INT_LOW_US(16'h0004),
        .INT_HIGH_US(16'h0008), .INIT_CYC(8)) dut_u (.clk_sys, .sys_rst, .reset_pin,
        .cs_n, .vdd_ok, .fault_pin, .selftest_pass, .cfg_wr, .ccp_wr, .run_wr, .run_wdata,
        .swrst_wr, .crc_req, .int_stat_rd, .poll_act_us, .poll_per_us, .int_n, .int_stat,
        .spi_por_flag, .spi_en, .run_on, .monitor_en, .wet_en, .sample_last, .ccp_en,
        .crc_en, .cfg_wr_ok, .cfg_word, .clean_current_cfg_reg, .ctrl_state);

    host_model host_u (.clk_sys, .cs_n, .int_stat_rd, .reset_pin);

    // 250 MHz core clock
    initial
    begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Exact compare; case inequality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Window compare for measured durations in clocks
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Selects the watched output for the bounded wait
    function automatic logic pick(input int s);
        case (s)
            0: return int_n;
            1: return wet_en;
            2: return ccp_en;
            default: return ctrl_state === smon_pkg::ST_IDLE;
        endcase
    endfunction

    // Counts clocks until the output reaches v; gives up after lim
    task automatic wait_lvl(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (pick(s) !== v && n < lim)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // One-cycle strobe: 0 config, 1 clean-current, 2 run bit, 3 soft reset
    task automatic pulse(input int k, input logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        cfg_wr = {k == 0, d};
        ccp_wr = {k == 1, d};
        run_wr = (k == 2);
        run_wdata = d[0];
        swrst_wr = (k == 3);
        #1 ok = cfg_wr_ok;
        @(negedge clk_sys);
        cfg_wr.valid = 1'h0;
        ccp_wr.valid = 1'h0;
        run_wr = 1'h0;
        swrst_wr = 1'h0;
    endtask

    // Waits for the end of initialisation and checks the power-on state
    task automatic t_boot(input logic [5:0] exp_stat);
        int n;
        wait_lvl(3, 1'h1, 4001, n);
        chk_rng(n, 1, 4000);
        repeat (2) @(negedge clk_sys);
        chk(16'(int_stat), 16'(exp_stat));
        chk(16'(spi_por_flag), 16'h0001);
        chk(16'(int_n), 16'h0000);
        chk(cfg_word, `SMON_CFG_RST);
        chk(clean_current_cfg_reg, `SMON_CCP_RST);
        $display("boot test done");
    endtask

    // Interrupt pulse train, then clearing by a frame that reads status
    task automatic t_irq();
        int n;
        wait_lvl(0, 1'h1, 100, n);
        wait_lvl(0, 1'h0, 100, n);
        wait_lvl(0, 1'h1, 100, n);
        chk_rng(n, 12, 20);
        wait_lvl(0, 1'h0, 100, n);
        chk_rng(n, 28, 36);
        host_u.frame(1'h0);
        chk(16'(int_stat.por), 16'h0001);
        host_u.frame(1'h1);
        chk(16'(int_stat), 16'h0000);
        wait_lvl(0, 1'h0, 60, n);
        chk_rng(n, 60, 60);
        $display("interrupt test done");
    endtask

    // Run bit, write lock while running, polling phase lengths
    task automatic t_run();
        int a, g, c, w;
        logic ok;
        // A shorter window and period than at start-up
        poll_act_us = 16'h0002;
        poll_per_us = 16'h0032;
        pulse(0, 16'h1234, ok);
        chk(16'(ok), 16'h0001);
        pulse(1, 16'h0004, ok);
        pulse(2, 16'h0001, ok);
        repeat (2) @(negedge clk_sys);
        chk(16'(run_on & monitor_en), 16'h0001);
        pulse(0, 16'hbeef, ok);
        chk(16'(ok), 16'h0000);
        chk(cfg_word, 16'h1234);
        pulse(1, 16'h0005, ok);
        chk(clean_current_cfg_reg, 16'h0005);
        crc_req = 1'h1;
        #1 chk(16'(crc_en), 16'h0001);
        @(negedge clk_sys);
        crc_req = 1'h0;
        // Skip the first, possibly partial, period
        wait_lvl(2, 1'h1, 300, a);
        wait_lvl(2, 1'h0, 300, a);
        wait_lvl(1, 1'h1, 300, a);
        wait_lvl(1, 1'h0, 300, a);
        chk(16'(sample_last), 16'h0001);
        chk_rng(a, 7, 9);
        wait_lvl(2, 1'h1, 300, g);
        chk_rng(g, 76, 84);
        wait_lvl(2, 1'h0, 300, c);
        chk_rng(c, 16, 24);
        wait_lvl(1, 1'h1, 300, w);
        chk_rng(a + g + c + w, 196, 204);
        pulse(2, 16'h0000, ok);
        repeat (2) @(negedge clk_sys);
        chk(16'(monitor_en | wet_en), 16'h0000);
        pulse(0, 16'h00a5, ok);
        chk(cfg_word, 16'h00a5);
        $display("run test done");
    endtask

    // Fault reaction time, then logic supply loss with a write attempt
    task automatic t_fault();
        int n;
        logic ok;
        @(negedge clk_sys);
        fault_pin.thermal_warning = 1'h1;
        wait_lvl(0, 1'h0, 100, n);
        chk_rng(n, 1, 80);
        chk(16'(int_stat.fault.thermal_warning), 16'h0001);
        fault_pin.thermal_warning = 1'h0;
        vdd_ok = 1'h0;
        repeat (6) @(negedge clk_sys);
        chk(16'(spi_en), 16'h0000);
        pulse(0, 16'h7777, ok);
        chk(16'(ok), 16'h0000);
        chk(cfg_word, 16'h00a5);
        vdd_ok = 1'h1;
        repeat (6) @(negedge clk_sys);
        $display("fault test done");
    endtask

    // Soft reset with an interrupt pending, failing then passing self-check
    task automatic t_swrst();
        logic ok;
        selftest_pass = 1'h0;
        pulse(3, 16'h0001, ok);
        chk(16'(run_on), 16'h0000);
        t_boot(6'h30);
        selftest_pass = 1'h1;
        pulse(3, 16'h0001, ok);
        t_boot(6'h20);
    endtask

    // Reset pin held high, then released
    task automatic t_hwrst();
        logic ok;
        pulse(0, 16'h00aa, ok);
        fork
            host_u.hw_reset(20);
            begin
                repeat (8) @(negedge clk_sys);
                chk(16'(ctrl_state), 16'(smon_pkg::ST_RESET));
                chk(16'(spi_en), 16'h0000);
                chk(16'(int_stat), 16'h0000);
                chk(cfg_word, 16'h0000);
            end
        join
        t_boot(6'h20);
    endtask

    // Counts and verdict, the single end of the run
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 52 us
    initial
    begin
        #200000;
        err_count++;
        final_report();
    end

    // Main sequence
    initial
    begin
        sys_rst = 1'h1;
        vdd_ok = 1'h1;
        selftest_pass = 1'h1;
        fault_pin = '0;
        cfg_wr = '0;
        ccp_wr = '0;
        run_wr = 1'h0;
        run_wdata = 1'h0;
        swrst_wr = 1'h0;
        crc_req = 1'h0;
        poll_act_us = 16'h0003;
        poll_per_us = 16'h003c;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'h0;
        t_boot(6'h20);
        // No frame before the logic supply has been valid long enough
        #45000;
        t_irq();
        t_run();
        t_fault();
        t_swrst();
        t_hwrst();
        final_report();
    end
endmodule
